// ==== rtl/deac_pkg.sv ====
// constants and types for the data eeprom access control block
package deac_pkg;

  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int PWRT_TIME_MS = 64;
  localparam int PWRT_CYCLES = PWRT_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int PROG_CYCLES_DEF = 200;
  localparam int UNLOCK_GAP_DEF = 2;
  localparam int ARRAY_DEPTH = 256;

  localparam logic [7:0] IDX_IRQ = 8'h0c;
  localparam logic [7:0] IDX_DATA = 8'h9a;
  localparam logic [7:0] IDX_ADDR = 8'h9b;
  localparam logic [7:0] IDX_CTRL = 8'h9c;
  localparam logic [7:0] IDX_UNLOCK = 8'h9d;

  localparam int CTRL_FETCH_BIT = 0;
  localparam int CTRL_PROG_BIT = 1;
  localparam int CTRL_PERMIT_BIT = 2;
  localparam int CTRL_ABORT_BIT = 3;
  localparam int IRQ_DONE_BIT = 7;

  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_HALF,
    KEY_FULL
  } deac_key_t;

endpackage : deac_pkg

// ==== rtl/deac_top.sv ====
// data eeprom access control: register slave, unlock check, read and write engine
// Functional notes
// - data register carries write and read byte
// - address register selects one of 256 bytes
// - control register upper four bits read zero
// - start bits set only by software, hardware clears
// - permit bit cleared at power-up only
// - reset during write sets abort flag
// - any reset clears data and address
// - write end clears start, sets done flag
// - unlock register reads zero, no storage
// - read loads data next cycle, then clears
// - data holds until next read or write
// - write needs 55h, AAh, start in order
// - unlock step spacing must be exact
// - start bit blocked while permit clear
// - started write completes despite permit clear
// - start bit reads one while writing
// - no writes during 64 ms power-up timer
// - byte write erases location before programming
// - write duration timed on chip
//
// The implementer's own choice: register access over Avalon-MM.
module deac_top
  import deac_pkg::*;
#(
  parameter int PWRT_COUNT = PWRT_CYCLES,
  parameter int PROG_COUNT = PROG_CYCLES_DEF,
  parameter int KEY_GAP = UNLOCK_GAP_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic master_clear_reset,
  input wire logic watchdog_timer_reset,
  input wire logic brownout_reset,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic program_done_flag,
  output logic program_in_progress
);

  localparam int PW = $clog2(PWRT_COUNT + 1);
  localparam int PGW = $clog2(PROG_COUNT + 1);
  localparam int GW = $clog2(KEY_GAP + 2);

  logic [2:0] rst_meta;
  logic [2:0] rst_sync;
  logic sys_rst;
  logic phase;
  logic req;
  logic acc;
  logic rd_acc;
  logic wr_acc;
  logic [7:0] word_idx;
  logic [7:0] read_mux;
  logic [7:0] wbyte;
  logic ctrl_wr;
  logic data_wr;
  logic addr_wr;
  logic key_wr;
  logic irq_wr;
  logic [7:0] eeprom_data_reg;
  logic [7:0] eeprom_addr_reg;
  logic fetch_start_bit;
  logic program_start_bit;
  logic program_permit_bit;
  logic program_abort_flag;
  logic next_permit;
  logic [7:0] mem [ARRAY_DEPTH];
  logic [7:0] mem_rd;
  logic [PGW-1:0] prog_cnt;
  logic [7:0] prog_addr;
  logic [7:0] prog_data;
  logic prog_end;
  logic start_ok;
  logic [PW-1:0] pwrt_cnt;
  logic pwrt_done;
  deac_key_t key;
  deac_key_t next_key;
  logic [GW-1:0] gap_cnt;
  logic gap_ok;

  function automatic logic wr_hit(input logic [7:0] idx, input logic [7:0] cur, input logic w);
    return w && (cur == idx);
  endfunction : wr_hit

  // external reset sources arrive asynchronously
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 3'h0;
      rst_sync <= 3'h0;
    end else begin
      rst_meta <= {brownout_reset, watchdog_timer_reset, master_clear_reset};
      rst_sync <= rst_meta;
    end
  end

  assign sys_rst = |rst_sync;

  // one wait state per access so read data can come from a flop
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~phase;
  assign acc = req & phase;
  assign rd_acc = avs_read & phase;
  assign wr_acc = avs_write & phase & avs_byteenable[0];
  assign word_idx = avs_address[9:2];
  assign wbyte = avs_writedata[7:0];
  assign ctrl_wr = wr_hit(IDX_CTRL, word_idx, wr_acc) & ~sys_rst;
  assign data_wr = wr_hit(IDX_DATA, word_idx, wr_acc) & ~sys_rst;
  assign addr_wr = wr_hit(IDX_ADDR, word_idx, wr_acc) & ~sys_rst;
  assign key_wr = wr_hit(IDX_UNLOCK, word_idx, wr_acc) & ~sys_rst;
  assign irq_wr = wr_hit(IDX_IRQ, word_idx, wr_acc) & ~sys_rst;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
    end else begin
      phase <= req & ~phase;
    end
  end

  always_comb begin
    read_mux = 8'h00;
    case (word_idx)
      IDX_DATA: read_mux = eeprom_data_reg;
      IDX_ADDR: read_mux = eeprom_addr_reg;
      IDX_CTRL: begin
        read_mux[CTRL_FETCH_BIT] = fetch_start_bit;
        read_mux[CTRL_PROG_BIT] = program_start_bit;
        read_mux[CTRL_PERMIT_BIT] = program_permit_bit;
        read_mux[CTRL_ABORT_BIT] = program_abort_flag;
      end
      IDX_IRQ: read_mux[IRQ_DONE_BIT] = program_done_flag;
      // unlock register has no storage and reads zero, as does any hole
      default: read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (req & ~phase) begin
      avs_readdata <= {24'h0, read_mux};
    end
  end

  // power-up timer runs once after power-on only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrt_cnt <= '0;
    end else if (!pwrt_done) begin
      pwrt_cnt <= pwrt_cnt + PW'(1);
    end
  end

  assign pwrt_done = (pwrt_cnt == PW'(PWRT_COUNT));

  // unlock sequence tracking
  assign gap_ok = (gap_cnt == GW'(KEY_GAP));

  always_comb begin
    next_key = key;
    if (acc) begin
      next_key = KEY_IDLE;
      if (key_wr && wbyte == KEY_FIRST) begin
        next_key = KEY_HALF;
      end
      if (key_wr && key == KEY_HALF && gap_ok && wbyte == KEY_SECOND) begin
        next_key = KEY_FULL;
      end
    end else if (key != KEY_IDLE && gap_cnt > GW'(KEY_GAP)) begin
      // a stall, such as an interrupt, breaks the sequence
      next_key = KEY_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      key <= KEY_IDLE;
    end else if (sys_rst) begin
      key <= KEY_IDLE;
    end else begin
      key <= next_key;
    end
  end

  // gap counter saturates one past the legal spacing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt <= '0;
    end else if (sys_rst) begin
      gap_cnt <= '0;
    end else if (acc) begin
      gap_cnt <= GW'(1);
    end else if (gap_cnt <= GW'(KEY_GAP)) begin
      gap_cnt <= gap_cnt + GW'(1);
    end
  end

  assign next_permit = ctrl_wr ? wbyte[CTRL_PERMIT_BIT] : program_permit_bit;

  // start needs the full key at the exact spacing, permit and an idle engine
  assign start_ok = ctrl_wr && wbyte[CTRL_PROG_BIT] && key == KEY_FULL && gap_ok
                    && next_permit
                    && pwrt_done
                    && !program_start_bit;

  assign prog_end = program_start_bit && (prog_cnt == PGW'(1)) && !sys_rst;

  // write engine: busy for exactly PROG_COUNT cycles, permit no longer looked at
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_start_bit <= 1'b0;
      prog_cnt <= '0;
    end else if (sys_rst) begin
      program_start_bit <= 1'b0;
      prog_cnt <= '0;
    end else if (start_ok) begin
      program_start_bit <= 1'b1;
      prog_cnt <= PGW'(PROG_COUNT);
    end else if (program_start_bit) begin
      prog_cnt <= prog_cnt - PGW'(1);
      if (prog_end) begin
        program_start_bit <= 1'b0;
      end
    end
  end

  // latched so the write ends on the byte and place it started with
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_addr <= ADDR_RST;
      prog_data <= DATA_RST;
    end else if (start_ok) begin
      prog_addr <= eeprom_addr_reg;
      prog_data <= eeprom_data_reg;
    end
  end

  assign program_in_progress = program_start_bit;

  // array is nonvolatile, so it takes no reset; an aborted write leaves it erased
  always_ff @(posedge ref_clk) begin
    if (start_ok) begin
      mem[eeprom_addr_reg] <= ERASED_BYTE;
    end else if (prog_end) begin
      mem[prog_addr] <= prog_data;
    end
  end

  assign mem_rd = mem[eeprom_addr_reg];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_start_bit <= 1'b0;
    end else if (sys_rst) begin
      fetch_start_bit <= 1'b0;
    end else if (fetch_start_bit) begin
      fetch_start_bit <= 1'b0;
    end else if (ctrl_wr && wbyte[CTRL_FETCH_BIT]) begin
      fetch_start_bit <= 1'b1;
    end
  end

  // a fetch wins over a software write landing in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eeprom_data_reg <= DATA_RST;
    end else if (sys_rst) begin
      eeprom_data_reg <= DATA_RST;
    end else if (fetch_start_bit) begin
      eeprom_data_reg <= mem_rd;
    end else if (data_wr) begin
      eeprom_data_reg <= wbyte;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eeprom_addr_reg <= ADDR_RST;
    end else if (sys_rst) begin
      eeprom_addr_reg <= ADDR_RST;
    end else if (addr_wr) begin
      eeprom_addr_reg <= wbyte;
    end
  end

  // only power-on clears it; the other resets leave it alone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_permit_bit <= 1'b0;
    end else if (ctrl_wr) begin
      program_permit_bit <= wbyte[CTRL_PERMIT_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_abort_flag <= 1'b0;
    end else if (sys_rst && program_start_bit) begin
      program_abort_flag <= 1'b1;
    end else if (ctrl_wr) begin
      program_abort_flag <= wbyte[CTRL_ABORT_BIT];
    end
  end

  // completion set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_done_flag <= 1'b0;
    end else if (sys_rst) begin
      program_done_flag <= 1'b0;
    end else if (prog_end) begin
      program_done_flag <= 1'b1;
    end else if (irq_wr) begin
      program_done_flag <= wbyte[IRQ_DONE_BIT];
    end
  end

  logic [31:0] h_len;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      h_len <= 32'h0;
    end else if (program_start_bit) begin
      h_len <= h_len + 32'h1;
    end else begin
      h_len <= 32'h0;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n || sys_rst);

  sequence s_prog_rise;
    !program_start_bit ##1 program_start_bit;
  endsequence

  sequence s_prog_fall;
    $fell(program_start_bit) && !$past(sys_rst);
  endsequence

  sequence s_fetch_done;
    ##1 (!fetch_start_bit && eeprom_data_reg == $past(mem_rd));
  endsequence

  property p_reset_clear;
    disable iff (!rst_n) sys_rst |=> (eeprom_data_reg == 8'h00 && eeprom_addr_reg == 8'h00);
  endproperty

  property p_abort_set;
    disable iff (!rst_n) sys_rst && program_start_bit |=> program_abort_flag && !program_start_bit;
  endproperty

  a_prog_length: assert property (s_prog_fall |-> h_len == PROG_COUNT)
    else $error("write cycle length wrong");
  a_done_on_end: assert property (s_prog_fall |-> program_done_flag)
    else $error("done flag not set at write end");
  a_start_needs_key: assert property (
    s_prog_rise |-> $past(key) == KEY_FULL && $past(gap_ok))
    else $error("write started without unlock");
  a_start_permit: assert property (s_prog_rise |-> program_permit_bit)
    else $error("write started with permit clear");
  a_pwrt_blocks: assert property (s_prog_rise |-> $past(pwrt_done))
    else $error("write started during power-up timer");
  a_fetch_single: assert property (fetch_start_bit |-> s_fetch_done)
    else $error("fetch did not load or clear");
  a_data_hold: assert property (
    !fetch_start_bit && !data_wr |=> $stable(eeprom_data_reg))
    else $error("data register changed unasked");
  a_busy_holds: assert property (program_start_bit && !prog_end |=> program_start_bit)
    else $error("write cycle ended early");
  a_start_sticky: assert property (
    ctrl_wr && !wbyte[CTRL_PROG_BIT] && program_start_bit && !prog_end |=> program_start_bit)
    else $error("software cleared start bit");
  a_permit_sw_only: assert property (!ctrl_wr |=> $stable(program_permit_bit))
    else $error("permit changed without a write");
  a_ctrl_top_zero: assert property (
    rd_acc && word_idx == IDX_CTRL |-> avs_readdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  a_unlock_zero: assert property (
    rd_acc && word_idx == IDX_UNLOCK |-> avs_readdata == 32'h0)
    else $error("unlock register read not zero");
  a_reset_clears: assert property (p_reset_clear)
    else $error("reset left data or address");
  a_abort_flag: assert property (p_abort_set)
    else $error("abort flag not set by reset");

endmodule : deac_top

// ==== test/deac_top_tb_top.sv ====
// self-checking bench for the data eeprom access control block
module deac_top_tb_top import deac_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PWRT = 40;
  localparam int PROG = 12;
  localparam int LIMIT = 4000;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] sres = 3'h0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic program_done_flag;
  logic program_in_progress;
  logic [31:0] rd;
  logic [31:0] seed = 32'd1585;
  logic [7:0] a;
  logic [7:0] d;
  int num_errors;
  int compares;
  int cycles;
  int run_len;
  int last_len;
  int starts;
  int mem [256];
  logic [7:0] k1s [4] = '{8'haa, 8'h55, 8'h55, 8'h55};
  logic [7:0] k2s [4] = '{8'h55, 8'h55, 8'haa, 8'h00};
  bit gaps [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

  deac_top #(.PWRT_COUNT(PWRT), .PROG_COUNT(PROG), .KEY_GAP(UNLOCK_GAP_DEF)) dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .master_clear_reset(sres[0]),
    .watchdog_timer_reset(sres[1]),
    .brownout_reset(sres[2]),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .program_done_flag(program_done_flag),
    .program_in_progress(program_in_progress)
  );

  always #12.5 ref_clk = ~ref_clk;

  // busy length and start count, measured independently of the bus
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (program_in_progress === 1'b1) begin
      if (run_len == 0) starts <= starts + 1;
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_len <= run_len;
      run_len <= 0;
    end
    if (cycles == LIMIT) begin
      num_errors++;
      print_verdict();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // request stays up on return so unlock steps can run with zero gap
  task automatic acc(input bit w, input logic [7:0] idx, input logic [7:0] val);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, val};
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
  endtask : acc

  task automatic rel();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : rel

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    acc(1'b1, idx, val);
    rel();
  endtask : wr

  task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00);
    rel();
    `CHK(rd, {24'h0, exp})
  endtask : chk

  task automatic unl(input logic [7:0] k1, input logic [7:0] k2, input bit gap,
                     input logic [7:0] cv);
    acc(1'b1, IDX_UNLOCK, k1); // a stall between the two keys only when gap is set
    if (gap) rel();
    acc(1'b1, IDX_UNLOCK, k2);
    acc(1'b1, IDX_CTRL, cv);
    rel();
  endtask : unl

  task automatic wbyte(input logic [7:0] ad, input logic [7:0] dv);
    wr(IDX_DATA, dv);
    wr(IDX_ADDR, ad);
    wr(IDX_CTRL, 8'h04);
    unl(KEY_FIRST, KEY_SECOND, 1'b0, 8'h06);
  endtask : wbyte

  task automatic fe(input logic [7:0] ad);
    wr(IDX_ADDR, ad);
    wr(IDX_CTRL, 8'h05);
  endtask : fe

  task automatic idle();
    while (program_in_progress !== 1'b0) @(posedge ref_clk);
  endtask : idle

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(IDX_DATA, DATA_RST);
    chk(IDX_ADDR, ADDR_RST);
    chk(IDX_CTRL, 8'h00);
    chk(IDX_IRQ, 8'h00);
    // a perfect sequence still inside the power-up window
    wbyte(8'h10, 8'h5a);
    chk(IDX_CTRL, 8'h04);
    repeat (PWRT) @(posedge ref_clk);
    `CHK(starts, 0)
    wr(IDX_CTRL, 8'h00);
    // start requested with the permit bit left clear in the same write
    unl(KEY_FIRST, KEY_SECOND, 1'b0, 8'h02);
    chk(IDX_CTRL, 8'h00);
    `CHK(starts, 0)
    wr(IDX_CTRL, 8'hfc);
    chk(IDX_CTRL, 8'h0c);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_UNLOCK, KEY_FIRST);
    chk(IDX_UNLOCK, 8'h00);
    chk(8'h10, 8'h00);
    // low byte lane disabled: the write is answered but lands nowhere
    avs_byteenable <= 4'he;
    wr(IDX_DATA, 8'h77);
    avs_byteenable <= 4'hf;
    chk(IDX_DATA, 8'h5a);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      a = seed[7:0];
      d = seed[15:8];
      wbyte(a, d);
      chk(IDX_CTRL, 8'h06);
      // permit dropped mid-write must not stop it
      wr(IDX_CTRL, 8'h00);
      idle();
      mem[a] = d;
      chk(IDX_IRQ, 8'h80);
      `CHK(last_len, PROG)
      `CHK(starts, i + 1)
      chk(IDX_CTRL, 8'h00);
      `CHK(program_done_flag, 1'b1)
      fe(a);
      chk(IDX_DATA, mem[a][7:0]);
      chk(IDX_CTRL, 8'h04);
      wr(IDX_ADDR, a ^ 8'h01);
      chk(IDX_DATA, mem[a][7:0]);
      wr(IDX_IRQ, 8'h00);
      chk(IDX_IRQ, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CTRL, 8'h04);
      unl(k1s[i], k2s[i], gaps[i], 8'h06);
      chk(IDX_CTRL, 8'h04);
    end
    `CHK(starts, 4)
    for (int r = 0; r < 3; r++) begin
      seed = xs(seed);
      a = seed[7:0];
      d = seed[15:8];
      wbyte(a, d);
      sres[r] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sres <= 3'h0;
      repeat (4) @(posedge ref_clk);
      mem[a] = 8'hff;
      chk(IDX_CTRL, 8'h0c);
      chk(IDX_DATA, 8'h00);
      chk(IDX_ADDR, 8'h00);
      wr(IDX_CTRL, 8'h04);
      fe(a);
      chk(IDX_DATA, mem[a][7:0]);
      // software recovery: reload and rewrite the lost byte
      wbyte(a, d);
      idle();
      mem[a] = d;
      fe(a);
      chk(IDX_DATA, mem[a][7:0]);
      chk(IDX_CTRL, 8'h04);
      wr(IDX_IRQ, 8'h00);
    end
    print_verdict();
  end
endmodule : deac_top_tb_top
